// *** kms_scanner.v ***
// What this block does
// R1 - Four row registers, four key bits each
// R2 - Bits read 1 at reset and idle
// R3 - Pressed key clears its bit to 0
// R4 - Register picks row, bit picks column
// R5 - Interrupt when scan differs from previous
// R6 - Key release also counts as change
// R7 - Four sense inputs sample matrix rows
// R8 - Four column outputs select key columns
// R9 - Host enables pins and irq before start
// R10 - One column at a time, latch senses
// R11 - Irq held until ack; frozen when disabled
`timescale 1ns/10ps
`default_nettype none
`include "kms_regs.vh"

module kms_scanner (
    input  wire       clk,               // 40 MHz clock
    input  wire       reset,             // Sync reset, active high
    input  wire       matrix_pins_en,    // Enables column drive and sensing
    input  wire       irq_en,            // Enables change interrupt
    input  wire       scan_start,        // Level: scanning runs while high
    input  wire       irq_ack,           // One-cycle change acknowledge
    input  wire [3:0] matrix_sense_in,   // Row senses, active low
    output reg  [3:0] matrix_column_out, // Column drives, active low
    output reg  [3:0] row0_scan_data,    // Row 0, bit n = column n
    output reg  [3:0] row1_scan_data,    // Row 1
    output reg  [3:0] row2_scan_data,    // Row 2
    output reg  [3:0] row3_scan_data,    // Row 3
    output reg        key_change_irq,    // Change request, level
    output reg        scan_busy          // Scanner running
);

    // --------------------------------------------------------
    // States and helpers
    // --------------------------------------------------------
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_SETTLE = 3'b010;
    localparam [2:0] ST_SAMPLE = 3'b100;
    localparam integer SETTLE_LAST_I = `KMS_SETTLE_CYC - 1;
    localparam [`KMS_CNT_W-1:0] SETTLE_LAST =
        SETTLE_LAST_I[`KMS_CNT_W-1:0];

    // Active-low one-hot drive for a column
    function [3:0] col_drive;
        input [1:0] col;
        begin
            col_drive = ~(4'h1 << col);
        end
    endfunction

    // Replace bit col of a row word
    function [3:0] put_bit;
        input [3:0] word;
        input [1:0] col;
        input       val;
        reg   [3:0] m;
        begin
            m = 4'h1 << col;
            put_bit = val ? (word | m) : (word & ~m);
        end
    endfunction

    reg [2:0]            state_reg;
    reg [2:0]            state_next;
    reg [1:0]            col_reg;
    reg [`KMS_CNT_W-1:0] cnt_reg;
    reg [3:0]            shadow0_reg;
    reg [3:0]            shadow1_reg;
    reg [3:0]            shadow2_reg;
    reg [3:0]            shadow3_reg;
    wire                 running;
    wire                 sample_now;
    wire                 frame_end;
    wire                 changed;
    wire [3:0]           row0_next;
    wire [3:0]           row1_next;
    wire [3:0]           row2_next;
    wire [3:0]           row3_next;

    assign running = scan_start & matrix_pins_en;
    // R11 - no sampling once stopped
    assign sample_now = (state_reg == ST_SAMPLE) && running;
    assign frame_end = sample_now && (col_reg == 2'd3);

    // Shadow rows with the current column merged in
    assign row0_next = put_bit(shadow0_reg, col_reg, matrix_sense_in[0]);
    assign row1_next = put_bit(shadow1_reg, col_reg, matrix_sense_in[1]);
    assign row2_next = put_bit(shadow2_reg, col_reg, matrix_sense_in[2]);
    assign row3_next = put_bit(shadow3_reg, col_reg, matrix_sense_in[3]);

    // R5 - compare frame to previous
    // R6 - any bit flip, release included
    assign changed = frame_end &&
        ({row3_next, row2_next, row1_next, row0_next} !=
         {row3_scan_data, row2_scan_data,
          row1_scan_data, row0_scan_data});

    // --------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // R9 - start only once pins enabled
                if (running)
                    state_next = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (!running)
                    state_next = ST_IDLE;
                else if (cnt_reg == SETTLE_LAST)
                    state_next = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                state_next = running ? ST_SETTLE : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            scan_busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            scan_busy <= (state_next != ST_IDLE);
        end
    end

    // --------------------------------------------------------
    // Settle counter and column index
    // --------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            cnt_reg <= {`KMS_CNT_W{1'b0}};
            col_reg <= 2'd0;
        end else begin
            if (state_reg == ST_SETTLE && state_next == ST_SETTLE)
                cnt_reg <= cnt_reg + 1'b1;
            else
                cnt_reg <= {`KMS_CNT_W{1'b0}};
            // Restart always begins at column 0
            if (state_next == ST_IDLE)
                col_reg <= 2'd0;
            else if (state_reg == ST_SAMPLE)
                col_reg <= col_reg + 1'b1;
        end
    end

    // --------------------------------------------------------
    // Column drive
    // --------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            matrix_column_out <= `KMS_ROW_IDLE;
        end else begin
            // R8 - drive selected column low
            // R10 - one column at a time
            if (state_next == ST_IDLE)
                matrix_column_out <= `KMS_ROW_IDLE;
            else if (state_reg == ST_SAMPLE)
                matrix_column_out <= col_drive(col_reg + 2'd1);
            else
                matrix_column_out <= col_drive(col_reg);
        end
    end

    // --------------------------------------------------------
    // Scan data
    // --------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            // R2 - all keys idle after reset
            shadow0_reg    <= `KMS_ROW_IDLE;
            shadow1_reg    <= `KMS_ROW_IDLE;
            shadow2_reg    <= `KMS_ROW_IDLE;
            shadow3_reg    <= `KMS_ROW_IDLE;
            row0_scan_data <= `KMS_ROW_IDLE;
            row1_scan_data <= `KMS_ROW_IDLE;
            row2_scan_data <= `KMS_ROW_IDLE;
            row3_scan_data <= `KMS_ROW_IDLE;
        end else if (sample_now) begin
            // R7 - sense input n is row n
            // R3 - low sense clears key bit
            // R4 - row index, column bit
            shadow0_reg <= put_bit(shadow0_reg, col_reg,
                                   matrix_sense_in[0]);
            shadow1_reg <= put_bit(shadow1_reg, col_reg,
                                   matrix_sense_in[1]);
            shadow2_reg <= put_bit(shadow2_reg, col_reg,
                                   matrix_sense_in[2]);
            shadow3_reg <= put_bit(shadow3_reg, col_reg,
                                   matrix_sense_in[3]);
            // R1 - publish whole frame
            // R11 - only while scanning
            if (frame_end) begin
                row0_scan_data <= row0_next;
                row1_scan_data <= row1_next;
                row2_scan_data <= row2_next;
                row3_scan_data <= row3_next;
            end
        end
    end

    // --------------------------------------------------------
    // Change request
    // --------------------------------------------------------
    always @(posedge clk) begin
        if (reset)
            key_change_irq <= 1'b0;
        // R11 - set wins over acknowledge
        else if (changed && irq_en)
            key_change_irq <= 1'b1;
        else if (irq_ack)
            key_change_irq <= 1'b0;
    end

endmodule
`default_nettype wire

// *** kms_regs.vh ***
`ifndef KMS_REGS_VH
`define KMS_REGS_VH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define KMS_ROWS          4
`define KMS_COLS          4
`define KMS_ROW_IDLE      4'hf

// ------------------------------------------------------------
// Scan timing
// ------------------------------------------------------------
`define KMS_CLK_MHZ       40
`define KMS_SETTLE_NS     1000
`define KMS_SETTLE_CYC    ((`KMS_SETTLE_NS * `KMS_CLK_MHZ + 999) / 1000)
`define KMS_CNT_W         6

`endif

// *** kms_scanner_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module kms_scanner_assertions (
    input wire logic       clk,               // Clock
    input wire logic       reset,             // Reset
    input wire logic       matrix_pins_en,    // Pins on
    input wire logic       irq_en,            // Irq on
    input wire logic       scan_start,        // Run
    input wire logic       irq_ack,           // Ack
    input wire logic [3:0] matrix_column_out, // Columns
    input wire logic [3:0] row0_scan_data,    // Row 0
    input wire logic [3:0] row1_scan_data,    // Row 1
    input wire logic [3:0] row2_scan_data,    // Row 2
    input wire logic [3:0] row3_scan_data,    // Row 3
    input wire logic       key_change_irq,    // Irq
    input wire logic       scan_busy          // Busy
);
    wire logic [15:0] rows;
    wire logic        run;
    assign rows = {row3_scan_data, row2_scan_data,
                   row1_scan_data, row0_scan_data};
    assign run = scan_start & matrix_pins_en;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_idle: assert property (disable iff (1'b0)
        reset |=> rows == 16'hffff && !key_change_irq) else $error("reset");
    a_one_column: assert property ($onehot0(~matrix_column_out))
        else $error("columns");
    a_stop_idle: assert property (!run |=> matrix_column_out == 4'hf)
        else $error("stop");
    a_irq_hold: assert property (key_change_irq && !irq_ack |=>
        key_change_irq) else $error("hold");
    a_irq_cause: assert property ($rose(key_change_irq) |->
        rows != $past(rows)) else $error("cause");
    a_release_irq: assert property ($past(irq_en) && !$past(reset) &&
        rows != $past(rows) |-> key_change_irq) else $error("change");
    a_rows_frozen: assert property (!run |=> $stable(rows))
        else $error("frozen");
    a_update_col3: assert property (!$past(reset) &&
        rows != $past(rows) |-> $past(matrix_column_out) == 4'h7)
        else $error("update");
    a_irq_gate: assert property (!irq_en && !key_change_irq |=>
        !key_change_irq) else $error("gate");
    a_col_rotate: assert property (matrix_column_out != 4'hf &&
        $past(matrix_column_out) != 4'hf &&
        matrix_column_out != $past(matrix_column_out) |->
        matrix_column_out == {$past(matrix_column_out[2:0]),
                              $past(matrix_column_out[3])})
        else $error("rotate");
    cover property ($rose(key_change_irq));
    cover property (scan_busy && !run);
    cover property (!irq_en && rows != $past(rows));
endmodule
bind kms_scanner kms_scanner_assertions chk_u (.clk(clk), .reset(reset),
    .matrix_pins_en(matrix_pins_en), .irq_en(irq_en),
    .scan_start(scan_start), .irq_ack(irq_ack),
    .matrix_column_out(matrix_column_out), .row0_scan_data(row0_scan_data),
    .row1_scan_data(row1_scan_data), .row2_scan_data(row2_scan_data),
    .row3_scan_data(row3_scan_data), .key_change_irq(key_change_irq),
    .scan_busy(scan_busy));
`default_nettype wire

// *** kms_key_matrix.sv ***
`timescale 1ns/10ps
`default_nettype none
module kms_key_matrix (
    input  wire logic [15:0] pressed, // Key row*4+column
    input  wire logic [3:0]  cols,    // Column drives
    output var  logic [3:0]  sense    // Pulled-up rows
);
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            sense[r] = ~|(pressed[r*4 +: 4] & ~cols);
        end
    end
endmodule
`default_nettype wire

// *** tb_key_matrix_scanner_4x4.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_key_matrix_scanner_4x4;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        pins_en = 1'b0;
    logic        irq_en = 1'b0;
    logic        run = 1'b0;
    logic        ack = 1'b0;
    logic        irq_d = 1'b0;
    logic [15:0] keys = 16'h0000;
    logic [15:0] nk;
    logic [15:0] ev;
    logic [3:0]  sense, cols, r0, r1, r2, r3;
    logic        irq;
    logic        busy;
    logic [15:0] exp_q[$];
    int          miscompares = 0;
    int          num_checks = 0;
    always #12.5 clk = ~clk;
    kms_scanner dut_u (.clk(clk), .reset(reset), .matrix_pins_en(pins_en),
        .irq_en(irq_en), .scan_start(run), .irq_ack(ack),
        .matrix_sense_in(sense), .matrix_column_out(cols),
        .row0_scan_data(r0), .row1_scan_data(r1), .row2_scan_data(r2),
        .row3_scan_data(r3), .key_change_irq(irq), .scan_busy(busy));
    kms_key_matrix mat_u (.pressed(keys), .cols(cols), .sense(sense));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(negedge clk) begin
        if (irq === 1'b1 && irq_d !== 1'b1) begin
            ev = exp_q.pop_front();
            `CHK("rows", ev, {r3, r2, r1, r0})
        end
        irq_d <= irq;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        nk = 16'($urandom(32'h02d6a80d));
        repeat (3) @(negedge clk);
        reset = 1'b0;
        `CHK("rst", 16'hffff, {r3, r2, r1, r0})
        pins_en = 1'b1;
        irq_en = 1'b1;
        for (int i = 0; i < 7; i++) begin
            nk = (i == 6) ? 16'h0000 : 16'($urandom);
            if (nk == keys) nk = nk ^ 16'h8001;
            run = 1'b0;
            keys = nk;
            exp_q.push_back(~nk);
            @(negedge clk);
            run = 1'b1;
            for (int n = 0; n < 400 && irq !== 1'b1; n++) @(negedge clk);
            repeat (4) @(negedge clk);
            `CHK("held", 1'b1, irq)
            `CHK("busy", 1'b1, busy)
            ack = 1'b1;
            @(negedge clk);
            ack = 1'b0;
            `CHK("clr", 1'b0, irq)
        end
        run = 1'b0;
        keys = 16'h0f0f;
        repeat (200) @(negedge clk);
        `CHK("stop", ~nk, {r3, r2, r1, r0})
        `CHK("idle", 1'b0, busy)
        irq_en = 1'b0;
        run = 1'b1;
        repeat (200) @(negedge clk);
        `CHK("noirq", 16'hf0f0, {r3, r2, r1, r0})
        `CHK("gate", 1'b0, irq)
        pins_en = 1'b0;
        keys = 16'h00f0;
        repeat (200) @(negedge clk);
        `CHK("pins", 16'hf0f0, {r3, r2, r1, r0})
        `CHK("cols", 4'hf, cols)
        complete_run();
    end
endmodule
`default_nettype wire
